// [hdl/accc_params.svh]
`ifndef ACCC_PARAMS_SVH
`define ACCC_PARAMS_SVH
`define ACCC_OFF_WORD0 8'h00
`define ACCC_OFF_TASK 8'h24
`define ACCC_OFF_TARGET 8'h28
`define ACCC_OFF_GO 8'h2c
`define ACCC_OFF_STAT 8'h30
`define ACCC_OFF_CODE 8'h34
`define ACCC_OFF_INIT 8'h38
`define ACCC_OFF_EXP 8'h3c
`define ACCC_OFF_CHCFG 8'h40
`define ACCC_OFF_CHTHR 8'h60
`define ACCC_OFF_LAST 8'h7c
`define ACCC_POS_FAULT_DIS 7
`define ACCC_POS_ALARM_EN 12
`define ACCC_POS_INIT_SEEN 8
`define ACCC_POS_INIT_ERR 9
`define ACCC_LEN_WORDS 16'h0003
`define ACCC_THR_MAX 16'h7fff
`define ACCC_THR_MIN 16'h8001
`define ACCC_THR_BAD 16'h8000
`define ACCC_RST_HI 16'h7fff
`define ACCC_RST_LO 16'h8001
`define ACCC_RST_TASK 16'h0001
`define ACCC_ERR_NONE 16'h0000
`define ACCC_ERR_LEN 16'h0001
`define ACCC_ERR_PAD 16'h0002
`define ACCC_ERR_CHAN 16'h0003
`define ACCC_ERR_RANGE 16'h0004
`define ACCC_ERR_ORDER 16'h0005
`define ACCC_BLINK_MS 250
`define ACCC_CLK_KHZ 100000
`define ACCC_BLINK_CYC (`ACCC_BLINK_MS * `ACCC_CLK_KHZ)
`endif

// [hdl/accc_pkg.sv]
package accc_pkg;
  typedef enum logic [2:0] {BS_TEST, BS_WAIT, BS_OK, BS_ERR, BS_HALT} accc_board_t;
  typedef struct packed {
    logic [8:0][15:0] words;
    logic [15:0] task_id;
    logic [15:0] target;
    logic err;
    logic [15:0] code;
    logic [7:0] perm;
    logic cfg_seen;
    logic cfg_err;
    logic [6:0] exp_cfg;
    logic [7:0] fault_en;
    logic [7:0] alarm_en;
    logic [7:0][15:0] hi;
    logic [7:0][15:0] lo;
    logic [7:0] hi_en;
    logic [7:0] lo_en;
    logic [16:0] sy1;
    logic [16:0] sy2;
    accc_board_t bstate;
    logic board_led;
    logic port_led;
    logic [6:0] exp_led;
    logic [31:0] rdata;
    logic slverr;
  } accc_state_t;
  typedef struct packed {
    logic [31:0] cnt;
    logic blink;
  } accc_blink_t;
endpackage

// [hdl/accc_blink.sv]
`timescale 1ns/100ps
`default_nettype none
module accc_blink import accc_pkg::*; #(
  parameter int unsigned HALF_CYC = 25000000
) (
  input wire logic clk,
  input wire logic rst_n,
  output logic blink
);
  accc_blink_t s_q, s_d;

  // free-running square wave shared by every flashing led so they flash in step
  always_comb begin
    s_d = s_q;
    if (s_q.cnt == 32'(HALF_CYC - 1)) begin
      s_d.cnt = '0;
      s_d.blink = ~s_q.blink;
    end else begin
      s_d.cnt = s_q.cnt + 32'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign blink = s_q.blink;
endmodule
`default_nettype wire

// [hdl/accc_top.sv]
// Local design decisions: the register offsets and the APB interface to the registers.
`timescale 1ns/100ps
`default_nettype none
`include "accc_params.svh"
module accc_top import accc_pkg::*; #(
  parameter int unsigned BLINK_CYC = `ACCC_BLINK_CYC
) (
  input wire logic SYS_CLK,
  input wire logic RST_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic SELF_TEST_PASS,
  input wire logic BOARD_FAIL,
  input wire logic EXP_BUS_OK,
  input wire logic [6:0] EXP_RESPONDING,
  input wire logic [6:0] EXP_FAIL,
  output logic BOARD_LED,
  output logic PORT_LED,
  output logic [6:0] EXP_LED,
  output logic CMD_ERROR,
  output logic [7:0] FAULT_REPORT_EN,
  output logic [7:0] ALARM_INT_EN,
  output logic [7:0] HI_ALARM_EN,
  output logic [7:0] LO_ALARM_EN
);
  accc_state_t s_q, s_d;
  logic blink;
  logic wr;
  logic go_w;
  logic [15:0] chk;
  logic [2:0] ch_idx;
  logic [15:0] w0;
  logic [15:0] w1;
  logic [15:0] w2;

  // whole command but the setup word checked before anything is touched
  function automatic logic [15:0] check_cmd(input logic [8:0][15:0] w, input logic [15:0] t);
    logic [15:0] c;
    c = `ACCC_ERR_NONE;
    if (w[0] != `ACCC_LEN_WORDS) begin
      c = `ACCC_ERR_LEN;
    end else if ((w[1] | w[2] | w[3] | w[4] | w[5]) != 16'h0000) begin
      c = `ACCC_ERR_PAD;
    end else if (t == 16'h0000 || t > 16'h0008) begin
      c = `ACCC_ERR_CHAN;
    end else if (w[7] == `ACCC_THR_BAD || w[8] == `ACCC_THR_BAD) begin
      c = `ACCC_ERR_RANGE;
    end else if ($signed(w[7]) <= $signed(w[8])) begin
      c = `ACCC_ERR_ORDER;
    end
    return c;
  endfunction

  function automatic accc_state_t rst_state();
    accc_state_t r;
    r = '0;
    r.bstate = BS_TEST;
    r.task_id = `ACCC_RST_TASK;
    r.fault_en = 8'hff;
    for (int i = 0; i < 8; i++) begin
      r.hi[i] = `ACCC_RST_HI;
      r.lo[i] = `ACCC_RST_LO;
    end
    return r;
  endfunction

  // returns {slverr, data}; unaligned or out-of-map addresses answer with an error
  function automatic logic [32:0] read_reg(input accc_state_t s, input logic [7:0] a);
    logic [32:0] r;
    r = '0;
    if (a[1:0] != 2'b00 || a > `ACCC_OFF_LAST) begin
      r[32] = 1'b1;
    end else if (a < `ACCC_OFF_TASK) begin
      r[15:0] = s.words[a[5:2]];
    end else if (a >= `ACCC_OFF_CHTHR) begin
      r[31:0] = {s.hi[a[4:2]], s.lo[a[4:2]]};
    end else if (a >= `ACCC_OFF_CHCFG) begin
      r[3:0] = {s.lo_en[a[4:2]], s.hi_en[a[4:2]], s.alarm_en[a[4:2]], s.fault_en[a[4:2]]};
    end else begin
      unique case (a)
        `ACCC_OFF_TASK: r[15:0] = s.task_id;
        `ACCC_OFF_TARGET: r[15:0] = s.target;
        `ACCC_OFF_GO: r[31:0] = '0;
        `ACCC_OFF_STAT: r[3:0] = {s.bstate, s.err};
        `ACCC_OFF_CODE: r[15:0] = s.code;
        `ACCC_OFF_INIT: r[9:0] = {s.cfg_err, s.cfg_seen, s.perm};
        `ACCC_OFF_EXP: r[6:0] = s.exp_cfg;
        default: r[32] = 1'b1;
      endcase
    end
    return r;
  endfunction

  accc_blink #(
    .HALF_CYC(BLINK_CYC)
  ) u_blink (
    .clk(SYS_CLK),
    .rst_n(RST_N),
    .blink(blink)
  );

  assign wr = PSEL & PENABLE & PWRITE;
  assign go_w = wr && PADDR == `ACCC_OFF_GO && PWDATA[0];
  // command words sit at block words seven to nine
  assign w0 = s_q.words[6];
  assign w1 = s_q.words[7];
  assign w2 = s_q.words[8];
  assign chk = check_cmd(s_q.words, s_q.task_id);
  assign ch_idx = 3'(s_q.task_id - 16'h0001);

  always_comb begin
    s_d = s_q;
    s_d.sy1 = {EXP_FAIL, EXP_RESPONDING, EXP_BUS_OK, BOARD_FAIL, SELF_TEST_PASS};
    s_d.sy2 = s_q.sy1;
    if (PSEL && !PENABLE) begin
      {s_d.slverr, s_d.rdata} = read_reg(s_q, PADDR);
    end
    if (wr) begin
      if (PADDR < `ACCC_OFF_TASK && PADDR[1:0] == 2'b00) begin
        s_d.words[PADDR[5:2]] = PWDATA[15:0];
      end
      unique case (PADDR)
        `ACCC_OFF_TASK: s_d.task_id = PWDATA[15:0];
        `ACCC_OFF_TARGET: s_d.target = PWDATA[15:0];
        `ACCC_OFF_STAT: begin
          if (PWDATA[0]) begin
            s_d.err = 1'b0;
          end
        end
        `ACCC_OFF_INIT: begin
          s_d.perm = PWDATA[7:0];
          if (PWDATA[`ACCC_POS_INIT_SEEN]) begin
            s_d.cfg_seen = 1'b1;
            s_d.cfg_err = PWDATA[`ACCC_POS_INIT_ERR];
          end
        end
        `ACCC_OFF_EXP: s_d.exp_cfg = PWDATA[6:0];
        default: ;
      endcase
    end
    // a command landing with an error clear still leaves the error set
    if (go_w) begin
      s_d.code = chk;
      if (chk != `ACCC_ERR_NONE) begin
        s_d.err = 1'b1;
      end else begin
        // bit positions are one-based in the setup word, so bit 8 is index 7
        s_d.fault_en[ch_idx] = ~w0[`ACCC_POS_FAULT_DIS];
        s_d.alarm_en[ch_idx] = w0[`ACCC_POS_ALARM_EN] & s_q.perm[ch_idx];
        s_d.hi[ch_idx] = w1;
        s_d.lo[ch_idx] = w2;
        s_d.hi_en[ch_idx] = w1 != `ACCC_THR_MAX;
        s_d.lo_en[ch_idx] = w2 != `ACCC_THR_MIN;
      end
    end
    unique case (s_q.bstate)
      BS_TEST: begin
        if (s_q.sy2[0]) begin
          s_d.bstate = BS_WAIT;
        end
      end
      BS_WAIT: begin
        if (s_q.cfg_seen) begin
          s_d.bstate = s_q.cfg_err ? BS_ERR : BS_OK;
        end
      end
      BS_OK, BS_ERR, BS_HALT: ;
    endcase
    // a failed board halts; nothing but reset leaves this state
    if (s_q.sy2[1]) begin
      s_d.bstate = BS_HALT;
    end
    s_d.board_led = (s_q.bstate == BS_WAIT) ? blink : (s_q.bstate == BS_OK);
    s_d.port_led = (s_q.bstate != BS_HALT) && s_q.sy2[2]
                   && ((s_q.sy2[9:3] & s_q.exp_cfg) != 7'h00);
    for (int i = 0; i < 7; i++) begin
      if (s_q.bstate == BS_HALT || s_q.sy2[10 + i]) begin
        s_d.exp_led[i] = 1'b0;
      end else begin
        s_d.exp_led[i] = s_q.exp_cfg[i] ? 1'b1 : blink;
      end
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      s_q <= rst_state();
    end else begin
      s_q <= s_d;
    end
  end

  // zero wait states: read data was captured in the setup cycle
  assign PREADY = 1'b1;
  assign PRDATA = s_q.rdata;
  assign PSLVERR = s_q.slverr;
  assign BOARD_LED = s_q.board_led;
  assign PORT_LED = s_q.port_led;
  assign EXP_LED = s_q.exp_led;
  assign CMD_ERROR = s_q.err;
  assign FAULT_REPORT_EN = s_q.fault_en;
  assign ALARM_INT_EN = s_q.alarm_en;
  assign HI_ALARM_EN = s_q.hi_en;
  assign LO_ALARM_EN = s_q.lo_en;

  property p_len;
    @(posedge SYS_CLK) disable iff (!RST_N)
    go_w && s_q.words[0] != 16'h0003 |=> CMD_ERROR && s_q.code == 16'h0001;
  endproperty
  a_len: assert property (p_len) else $error("bad length not rejected");

  property p_pad;
    @(posedge SYS_CLK) disable iff (!RST_N)
    go_w && s_q.words[0] == 16'h0003 && s_q.words[3] != 16'h0000 |=> CMD_ERROR;
  endproperty
  a_pad: assert property (p_pad) else $error("nonzero padding accepted");

  property p_apply;
    @(posedge SYS_CLK) disable iff (!RST_N)
    go_w && chk == 16'h0000 |=> s_q.hi[$past(ch_idx)] == $past(s_q.words[7])
      && s_q.lo[$past(ch_idx)] == $past(s_q.words[8]);
  endproperty
  a_apply: assert property (p_apply) else $error("thresholds not taken from words 8 and 9");

  property p_fault;
    @(posedge SYS_CLK) disable iff (!RST_N)
    go_w && chk == 16'h0000 |=> FAULT_REPORT_EN[$past(ch_idx)] == !$past(w0[7]);
  endproperty
  a_fault: assert property (p_fault) else $error("fault report bit wrong");

  property p_alarm;
    @(posedge SYS_CLK) disable iff (!RST_N)
    go_w && chk == 16'h0000 |=> ALARM_INT_EN[$past(ch_idx)] == ($past(w0[12])
      && $past(s_q.perm[ch_idx]));
  endproperty
  a_alarm: assert property (p_alarm) else $error("alarm interrupt enable wrong");

  property p_range;
    @(posedge SYS_CLK) disable iff (!RST_N)
    go_w && s_q.words[7] == 16'h8000 |-> chk != 16'h0000;
  endproperty
  a_range: assert property (p_range) else $error("threshold -32768 accepted");

  property p_keep;
    @(posedge SYS_CLK) disable iff (!RST_N)
    go_w && chk != 16'h0000 |=> $stable(s_q.hi) && $stable(s_q.lo) && $stable(FAULT_REPORT_EN)
      && $stable(ALARM_INT_EN) && $stable(HI_ALARM_EN) && $stable(LO_ALARM_EN) && CMD_ERROR;
  endproperty
  a_keep: assert property (p_keep) else $error("rejected command changed channel");

  property p_chan;
    @(posedge SYS_CLK) disable iff (!RST_N)
    go_w && s_q.words[0] == 16'h0003 && (s_q.words[1] | s_q.words[2] | s_q.words[3]
      | s_q.words[4] | s_q.words[5]) == 16'h0000
      && (s_q.task_id == 16'h0000 || s_q.task_id > 16'h0008) |=> s_q.code == 16'h0003;
  endproperty
  a_chan: assert property (p_chan) else $error("bad channel not rejected");

  property p_disable;
    @(posedge SYS_CLK) disable iff (!RST_N)
    go_w && chk == 16'h0000 && s_q.words[7] == 16'h7fff |=> !HI_ALARM_EN[$past(ch_idx)];
  endproperty
  a_disable: assert property (p_disable) else $error("full scale high alarm not off");

  property p_wait_led;
    @(posedge SYS_CLK) disable iff (!RST_N)
    s_q.bstate == BS_WAIT && !s_q.cfg_seen && !s_q.sy2[1] ##1 s_q.bstate == BS_WAIT
      |-> BOARD_LED == $past(blink);
  endproperty
  a_wait_led: assert property (p_wait_led) else $error("board led not flashing");

  property p_halt;
    @(posedge SYS_CLK) disable iff (!RST_N)
    s_q.sy2[1] |=> ##1 (!BOARD_LED && !PORT_LED && EXP_LED == 7'h00) [*2];
  endproperty
  a_halt: assert property (p_halt) else $error("leds lit after board failure");

  property p_port;
    @(posedge SYS_CLK) disable iff (!RST_N)
    (s_q.sy2[9:3] & s_q.exp_cfg) == 7'h00 |=> !PORT_LED;
  endproperty
  a_port: assert property (p_port) else $error("port led on with no responder");

  property p_sticky;
    @(posedge SYS_CLK) disable iff (!RST_N)
    CMD_ERROR && !(wr && PADDR == `ACCC_OFF_STAT && PWDATA[0]) |=> CMD_ERROR;
  endproperty
  a_sticky: assert property (p_sticky) else $error("error bit dropped without clear");

  property p_order;
    @(posedge SYS_CLK) disable iff (!RST_N)
    go_w && $signed(s_q.words[7]) <= $signed(s_q.words[8]) |=> CMD_ERROR;
  endproperty
  a_order: assert property (p_order) else $error("high threshold not above low accepted");

  property p_exp_fail;
    @(posedge SYS_CLK) disable iff (!RST_N)
    s_q.sy2[16:10] != 7'h00 |=> (EXP_LED & $past(s_q.sy2[16:10])) == 7'h00;
  endproperty
  a_exp_fail: assert property (p_exp_fail) else $error("failed expander led lit");

  property p_exp_on;
    @(posedge SYS_CLK) disable iff (!RST_N)
    s_q.bstate != BS_HALT && s_q.exp_cfg[0] && !s_q.sy2[10] |=> EXP_LED[0];
  endproperty
  a_exp_on: assert property (p_exp_on) else $error("configured expander led not on");

  property p_board_ok;
    @(posedge SYS_CLK) disable iff (!RST_N)
    s_q.bstate == BS_OK |=> BOARD_LED;
  endproperty
  a_board_ok: assert property (p_board_ok) else $error("board led off with valid config");

  property p_board_err;
    @(posedge SYS_CLK) disable iff (!RST_N)
    s_q.bstate == BS_ERR |=> !BOARD_LED;
  endproperty
  a_board_err: assert property (p_board_err) else $error("board led on with config error");

  property p_self_test;
    @(posedge SYS_CLK) disable iff (!RST_N)
    s_q.bstate == BS_TEST && s_q.sy2[0] && !s_q.sy2[1] |=> s_q.bstate == BS_WAIT;
  endproperty
  a_self_test: assert property (p_self_test) else $error("no wait after self test");
endmodule
`default_nettype wire

// [sim/accc_cpu_model.sv]
`timescale 1ns/100ps
`default_nettype none
`include "accc_params.svh"
module accc_cpu_model #(
  parameter int GAP = 8
) (
  input wire logic clk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  logic [31:0] rd = 0;
  logic err = 0;
  logic hung = 0;
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
  end
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1;
    @(posedge clk);
    for (int i = 0; i < 16 && pready !== 1'b1; i++) @(posedge clk);
    hung = hung | (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
    // released lines show the inverse, not a stale copy
    paddr <= ~a;
    pwdata <= ~d;
  endtask
  task automatic cmd(input logic [15:0] len, pad, w0, hi, lo, ch);
    xfer(1, 8'h00, {16'h0, len});
    for (int i = 1; i < 6; i++) xfer(1, 8'(4 * i), {16'h0, pad});
    xfer(1, 8'h18, {16'h0, w0});
    xfer(1, 8'h1c, {16'h0, hi});
    xfer(1, 8'h20, {16'h0, lo});
    xfer(1, `ACCC_OFF_TASK, {16'h0, ch});
    xfer(1, `ACCC_OFF_TARGET, 32'h0107);
    // spacing shortened far below 1 ms; the device enforces none
    repeat (GAP) @(posedge clk);
    xfer(1, `ACCC_OFF_GO, 32'h1);
  endtask
endmodule
`default_nettype wire

// [sim/tb_accc_top.sv]
`timescale 1ns/100ps
`default_nettype none
`include "accc_params.svh"
module tb_accc_top;
  logic clk = 0, rst_n = 0, stp = 0, bfail = 0, bus_ok = 0;
  logic [6:0] resp = 0, xfail = 0, exp_led;
  logic psel, penable, pwrite, pslverr, pready, board_led, port_led, cmd_err;
  logic [7:0] paddr, fault_en, alarm_en, hi_en, lo_en;
  logic [31:0] pwdata, prdata;
  int bad_count = 0, comparisons = 0;
  accc_top #(.BLINK_CYC(4)) uut (.SYS_CLK(clk), .RST_N(rst_n), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .SELF_TEST_PASS(stp),
    .BOARD_FAIL(bfail), .EXP_BUS_OK(bus_ok), .EXP_RESPONDING(resp), .EXP_FAIL(xfail),
    .BOARD_LED(board_led), .PORT_LED(port_led), .EXP_LED(exp_led), .CMD_ERROR(cmd_err),
    .FAULT_REPORT_EN(fault_en), .ALARM_INT_EN(alarm_en), .HI_ALARM_EN(hi_en),
    .LO_ALARM_EN(lo_en));
  accc_cpu_model cpu (.clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  initial begin
    forever #5 clk = ~clk;
  end
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic rchk(input string n, input logic [7:0] a, input logic [31:0] e);
    cpu.xfer(1'b0, a, 32'h0);
    chk(n, e, cpu.rd);
  endtask
  task automatic ticks(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic outs(input logic [31:0] e);
    ticks(1);
    chk("channel outputs", e, {fault_en, alarm_en, hi_en, lo_en});
  endtask
  task automatic t_board;
    int flips;
    flips = 0;
    @(posedge clk);
    stp <= 1;
    ticks(6);
    for (int i = 0; i < 30; i++) begin
      logic was;
      was = board_led;
      ticks(1);
      flips += int'(board_led !== was);
    end
    chk("flash", 1, 32'(flips > 3));
    cpu.xfer(1, `ACCC_OFF_INIT, 32'h101);
    ticks(6);
    chk("board led", 1, 32'(board_led));
    $display("test board done");
  endtask
  task automatic t_cmd;
    outs(32'hff000000);
    rchk("task reset", `ACCC_OFF_TASK, 32'h1);
    cpu.cmd(3, 0, 16'h1080, 16'h4e20, 16'hb1e0, 1);
    outs(32'hfe010101);
    rchk("ch1 thr", `ACCC_OFF_CHTHR, 32'h4e20b1e0);
    cpu.cmd(3, 0, 16'h1000, 16'h7fff, 16'hb1e0, 2);
    outs(32'hfe010103);
    rchk("ch2 cfg", 8'h44, 32'h9);
    $display("test command done");
  endtask
  task automatic t_errors;
    for (int i = 0; i < 5; i++) begin
      cpu.cmd(i == 0 ? 2 : 3, 16'(i == 1), 16'h0, i == 3 ? 16'h8000 : 16'(i == 4),
        i == 4 ? 16'h1 : 16'h8001, 16'(i != 2));
      outs(32'hfe010103);
      chk("error bit", 1, 32'(cmd_err));
      rchk("code", `ACCC_OFF_CODE, i + 1);
      cpu.xfer(1, `ACCC_OFF_STAT, 32'h1);
      ticks(1);
      chk("error clear", 0, 32'(cmd_err));
    end
    cpu.cmd(3, 0, 16'h0, 16'h7fff, 16'h8001, 1);
    outs(32'hff000002);
    rchk("unmapped", 8'h80, 32'h0);
    chk("slverr", 1, 32'(cpu.err));
    $display("test errors done");
  endtask
  task automatic t_leds;
    int flips;
    flips = 0;
    cpu.xfer(1, `ACCC_OFF_EXP, 32'h1);
    @(posedge clk);
    bus_ok <= 1;
    resp <= 7'h01;
    ticks(6);
    chk("port led", 1, 32'(port_led));
    chk("exp led", 1, 32'(exp_led[0]));
    resp <= 7'h02;
    ticks(6);
    chk("port led off", 0, 32'(port_led));
    for (int i = 0; i < 12; i++) begin
      logic was;
      was = exp_led[1];
      ticks(1);
      flips += int'(exp_led[1] !== was);
    end
    chk("exp led flash", 1, 32'(flips > 1));
    xfail <= 7'h01;
    ticks(6);
    chk("exp led fail", 0, 32'(exp_led[0]));
    bfail <= 1;
    ticks(6);
    chk("leds halted", 0, {board_led, port_led, exp_led});
    $display("test leds done");
  endtask
  task automatic t_reset;
    @(posedge clk);
    rst_n <= 0;
    bfail <= 0;
    xfail <= 7'h00;
    ticks(10);
    rst_n <= 1;
    ticks(1);
    chk("reset channels", 32'hff000000, {fault_en, alarm_en, hi_en, lo_en});
    chk("reset leds", 0, {board_led, port_led, cmd_err});
    rchk("reset thr", 8'h64, 32'h7fff8001);
    ticks(6);
    cpu.xfer(1, `ACCC_OFF_INIT, 32'h300);
    ticks(6);
    chk("board led error", 0, 32'(board_led));
    rchk("board state", `ACCC_OFF_STAT, 32'h6);
    $display("test reset done");
  endtask
  task automatic print_verdict;
    if (cpu.hung) bad_count++;
    $display("comparisons %0d bad_count %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1;
    t_board();
    t_cmd();
    t_errors();
    t_leds();
    t_reset();
    print_verdict();
  end
endmodule
`default_nettype wire
